// ==== verilog/ipr_defs.svh ====
// Offsets, field positions, reset values and counts of the priority resolver
`ifndef IPR_DEFS_SVH
`define IPR_DEFS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define IPR_PRIO_SEL_OFS  8'h3c
`define IPR_OPTION_OFS    8'h39
`define IPR_ADDR_W        8
`define IPR_DATA_W        8

// ****************************************************************
// Field positions
// ****************************************************************
`define IPR_BOOT_BIT      7
`define IPR_SPEC_BIT      6
`define IPR_MODE_A_BIT    5
`define IPR_PSEL_MSB      4
`define IPR_PSEL_LSB      0
`define IPR_EDGE_BIT      5

// ****************************************************************
// Reset values, counts and addresses
// ****************************************************************
`define IPR_PSEL_RESET    5'h06
`define IPR_PROT_CYCLES   64
`define IPR_NUM_MASK      18
`define IPR_NUM_PERIPH    17
`define IPR_BOOT_ROM_LO   16'hbe40
`define IPR_BOOT_ROM_HI   16'hbfff
`define IPR_SPECIAL_PAGE  8'hbf

`endif

// ==== verilog/ipr_pkg.sv ====
// Types shared by the priority resolver
package ipr_pkg;

  // Source identities in default priority order, none first
  typedef enum logic [4:0] {
    IPR_SRC_NONE, IPR_SRC_RESET, IPR_SRC_CLKMON, IPR_SRC_WDOG,
    IPR_SRC_ILLOP, IPR_SRC_SWI, IPR_SRC_NMIPIN, IPR_SRC_EXTINT,
    IPR_SRC_RTI, IPR_SRC_IC1, IPR_SRC_IC2, IPR_SRC_IC3, IPR_SRC_OC1,
    IPR_SRC_OC2, IPR_SRC_OC3, IPR_SRC_OC4, IPR_SRC_IC4OC5, IPR_SRC_TOF,
    IPR_SRC_PWM, IPR_SRC_PAOV, IPR_SRC_PAEDGE, IPR_SRC_SCI1,
    IPR_SRC_KBD, IPR_SRC_SPI, IPR_SRC_SCI2
  } ipr_src_t;

  typedef logic [4:0] ipr_psel_t;

endpackage

// ==== verilog/ipr_resolver.sv ====
// Reset and interrupt priority resolver with mode and priority register
//
// Behaviour
// - Reset, clock monitor, watchdog, illegal op, SWI, NMI pin ignore the I bit.
// - Non-maskable order: reset, clock monitor, watchdog, illegal op, SWI, NMI pin.
// - Default maskable order from external pin down to SCI2.
// - Select field lifts one maskable source; the rest keep default order.
// - Promoted source is still blocked by I bit and its local enable.
// - Each source keeps its own vector whatever is promoted.
// - Select field writes are ignored unless the I bit is set.
// - Select codes map to maskable sources as encoded.
// - Reserved select codes act as the external pin; 10101 treated likewise.
// - Reset loads 00110 into the select field.
// - After reset both interrupt pins are level sensitive.
// - Boot, special and mode A bits capture the mode pins at reset release.
// - Mode bits are writable only while the special bit is one.
// - Boot ROM is mapped at BE40 to BFFF only while the boot bit is one.
// - Special bit picks special variation; mode A picks expanded or test.
// - Slow periodic interrupt shares the NMI pin request and sixth place.
// - Edge select makes the pin falling-edge; once-writable in first 64 cycles, any time while the special bit is one.
`timescale 1ns/10ps
`include "ipr_defs.svh"

module ipr_resolver
  import ipr_pkg::*;
#(
  parameter int NUM_PERIPH = `IPR_NUM_PERIPH // Peripheral maskable sources
)
(
  input  wire logic                   CLK,            // 125 MHz clock
  input  wire logic                   RST_N,          // Async reset, low
  input  wire logic [7:0]             ADDR,           // Register address
  input  wire logic [7:0]             WDATA,          // Write data
  input  wire logic                   WR,             // Write strobe
  input  wire logic                   RD,             // Read strobe
  output logic      [7:0]             RDATA,          // Read data
  input  wire logic                   I_MASK,         // CPU I mask bit
  input  wire logic                   X_MASK,         // CPU X mask bit
  input  wire logic                   RESET_REQ,      // Power-on/pin reset
  input  wire logic                   CLKMON_FAIL,    // Clock monitor fail
  input  wire logic                   WATCHDOG_TIMEOUT, // Watchdog timeout
  input  wire logic                   ILLEGAL_OPCODE, // Illegal opcode trap
  input  wire logic                   SWI_REQ,        // Software interrupt
  input  wire logic                   NMI_PIN_N,      // Nonmaskable pin
  input  wire logic                   SLOW_PERIODIC_INT, // Slow periodic
  input  wire logic                   EXT_INT_PIN_N,  // Maskable ext pin
  input  wire logic [NUM_PERIPH-1:0]  PERIPH_REQ,     // Periph requests
  input  wire logic [NUM_PERIPH-1:0]  PERIPH_EN,      // Local enables
  input  wire logic                   INT_ACK,        // CPU took request
  input  wire logic                   MODE_PIN_A,     // Mode pin A
  input  wire logic                   MODE_PIN_B,     // Mode pin B
  output logic                        INT_PENDING,    // Request present
  output logic      [4:0]             INT_SOURCE,     // Winning source id
  output logic      [15:0]            INT_VECTOR,     // Winner vector addr
  output logic                        BOOT_ROM_MAPPED, // Boot ROM in map
  output logic                        SPECIAL_MODE,   // Special variation
  output logic                        MODE_A,         // Expanded or test
  output logic                        EXT_EDGE_SEL    // Pin edge sensing
);

  localparam int NM = NUM_PERIPH + 1; // Maskable count incl. external pin

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic                boot_rom_enable_bit_reg;
  logic                special_mode_bit_reg;
  logic                mode_a_bit_reg;
  ipr_psel_t           psel_reg;
  logic                ext_int_edge_select_reg;
  logic                edge_written_reg;
  logic [6:0]          prot_cnt_reg;
  logic                modes_taken_reg;
  logic                ext_pin_prev_reg;
  logic                ext_edge_latch_reg;
  logic [7:0]          rdata_reg;
  logic                pend_reg;
  ipr_src_t            src_reg;
  logic [15:0]         vec_reg;

  logic                wr_prio_sel;
  logic                wr_option;
  logic                prot_open;
  logic                ext_req;
  logic [NM-1:0]       mask_live;
  logic [4:0]          prom_idx;
  logic [NM-1:0]       mask_req;
  logic [NM-1:0]       mask_en;
  ipr_src_t            src_next;
  logic [15:0]         vec_next;
  logic [7:0]          rdata_next;

  assign wr_prio_sel = WR && (ADDR == `IPR_PRIO_SEL_OFS);
  assign wr_option = WR && (ADDR == `IPR_OPTION_OFS);
  assign prot_open = (prot_cnt_reg < 7'(`IPR_PROT_CYCLES));

  // ****************************************************************
  // Mode bits
  // ****************************************************************
  // Pins are taken in the first clock after release, never under reset
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      modes_taken_reg         <= 1'b0;
      boot_rom_enable_bit_reg <= 1'b0;
      special_mode_bit_reg    <= 1'b0;
      mode_a_bit_reg          <= 1'b0;
    end
    else if (!modes_taken_reg)
    begin
      modes_taken_reg         <= 1'b1;
      boot_rom_enable_bit_reg <= !MODE_PIN_B && !MODE_PIN_A;
      special_mode_bit_reg    <= !MODE_PIN_B;
      mode_a_bit_reg          <= MODE_PIN_A;
    end
    else if (wr_prio_sel && special_mode_bit_reg)
    begin
      boot_rom_enable_bit_reg <= WDATA[`IPR_BOOT_BIT];
      special_mode_bit_reg    <= WDATA[`IPR_SPEC_BIT];
      mode_a_bit_reg          <= WDATA[`IPR_MODE_A_BIT];
    end
  end

  // ****************************************************************
  // Priority select field
  // ****************************************************************
  // Changing order while interrupts are live could race the CPU
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      psel_reg <= `IPR_PSEL_RESET;
    else if (wr_prio_sel && I_MASK)
      psel_reg <= WDATA[`IPR_PSEL_MSB:`IPR_PSEL_LSB];
  end

  // ****************************************************************
  // Edge select with write-once window
  // ****************************************************************
  // Count saturates so the window stays closed until the next reset
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      prot_cnt_reg <= 7'h00;
    else if (prot_open)
      prot_cnt_reg <= prot_cnt_reg + 7'h01;
  end

  // Special modes may rewrite at any time
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ext_int_edge_select_reg <= 1'b0;
      edge_written_reg        <= 1'b0;
    end
    else if (wr_option && (special_mode_bit_reg ||
                           (prot_open && !edge_written_reg)))
    begin
      ext_int_edge_select_reg <= WDATA[`IPR_EDGE_BIT];
      edge_written_reg        <= 1'b1;
    end
  end

  // ****************************************************************
  // External pin sensing
  // ****************************************************************
  // A falling edge is held until the CPU takes it; a new edge wins
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ext_pin_prev_reg   <= 1'b1;
      ext_edge_latch_reg <= 1'b0;
    end
    else
    begin
      ext_pin_prev_reg <= EXT_INT_PIN_N;
      if (ext_pin_prev_reg && !EXT_INT_PIN_N)
        ext_edge_latch_reg <= 1'b1;
      else if (INT_ACK && (src_reg == IPR_SRC_EXTINT))
        ext_edge_latch_reg <= 1'b0;
    end
  end

  assign ext_req = ext_int_edge_select_reg ? ext_edge_latch_reg
                                           : !EXT_INT_PIN_N;

  // ****************************************************************
  // Maskable gating
  // ****************************************************************
  assign mask_req = {PERIPH_REQ, ext_req};
  assign mask_en  = {PERIPH_EN, 1'b1}; // External pin has no local enable

  genvar g;
  generate
    for (g = 0; g < NM; g++)
    begin : g_gate
      assign mask_live[g] = mask_req[g] && mask_en[g] && !I_MASK;
    end
  endgenerate

  // ****************************************************************
  // Select code to default-order index
  // ****************************************************************
  // Index 0 is the external pin; reserved codes fall back to it
  function automatic logic [4:0] psel_to_idx(input ipr_psel_t code);
    logic [4:0] idx;
    idx = 5'd0;
    case (code)
      5'h06:   idx = 5'd0;
      5'h07:   idx = 5'd1;
      5'h08:   idx = 5'd2;
      5'h09:   idx = 5'd3;
      5'h0a:   idx = 5'd4;
      5'h0b:   idx = 5'd5;
      5'h0c:   idx = 5'd6;
      5'h0d:   idx = 5'd7;
      5'h0e:   idx = 5'd8;
      5'h0f:   idx = 5'd9;
      5'h10:   idx = 5'd10;
      5'h11:   idx = 5'd12;
      5'h12:   idx = 5'd13;
      5'h13:   idx = 5'd16;
      5'h14:   idx = 5'd17;
      5'h17:   idx = 5'd11;
      5'h18:   idx = 5'd14;
      5'h19:   idx = 5'd15;
      default: idx = 5'd0;
    endcase
    return idx;
  endfunction

  assign prom_idx = psel_to_idx(psel_reg);

  // ****************************************************************
  // Vector table, independent of promotion
  // ****************************************************************
  // Reset-type vectors move to the special page in special modes
  function automatic logic [15:0] vec_of(input ipr_src_t s,
                                         input logic spec);
    logic [15:0] v;
    v = 16'h0000;
    case (s)
      IPR_SRC_RESET:   v = 16'hfffe;
      IPR_SRC_CLKMON:  v = 16'hfffc;
      IPR_SRC_WDOG:    v = 16'hfffa;
      IPR_SRC_ILLOP:   v = 16'hfff8;
      IPR_SRC_SWI:     v = 16'hfff6;
      IPR_SRC_NMIPIN:  v = 16'hfff4;
      IPR_SRC_EXTINT:  v = 16'hfff2;
      IPR_SRC_RTI:     v = 16'hfff0;
      IPR_SRC_IC1:     v = 16'hffee;
      IPR_SRC_IC2:     v = 16'hffec;
      IPR_SRC_IC3:     v = 16'hffea;
      IPR_SRC_OC1:     v = 16'hffe8;
      IPR_SRC_OC2:     v = 16'hffe6;
      IPR_SRC_OC3:     v = 16'hffe4;
      IPR_SRC_OC4:     v = 16'hffe2;
      IPR_SRC_IC4OC5:  v = 16'hffe0;
      IPR_SRC_TOF:     v = 16'hffde;
      IPR_SRC_PWM:     v = 16'hffd0;
      IPR_SRC_PAOV:    v = 16'hffdc;
      IPR_SRC_PAEDGE:  v = 16'hffda;
      IPR_SRC_SCI1:    v = 16'hffce;
      IPR_SRC_KBD:     v = 16'hffcc;
      IPR_SRC_SPI:     v = 16'hffd8;
      IPR_SRC_SCI2:    v = 16'hffd6;
      default:         v = 16'h0000;
    endcase
    if (spec && (s == IPR_SRC_RESET || s == IPR_SRC_CLKMON ||
                 s == IPR_SRC_WDOG))
      v = {`IPR_SPECIAL_PAGE, v[7:0]};
    return v;
  endfunction

  // ****************************************************************
  // Arbitration
  // ****************************************************************
  // Non-maskable first, then promoted source, then default order
  always_comb
  begin
    src_next = IPR_SRC_NONE;
    if (RESET_REQ)
      src_next = IPR_SRC_RESET;
    else if (CLKMON_FAIL)
      src_next = IPR_SRC_CLKMON;
    else if (WATCHDOG_TIMEOUT)
      src_next = IPR_SRC_WDOG;
    else if (ILLEGAL_OPCODE)
      src_next = IPR_SRC_ILLOP;
    else if (SWI_REQ)
      src_next = IPR_SRC_SWI;
    else if ((!NMI_PIN_N || SLOW_PERIODIC_INT) && !X_MASK)
      src_next = IPR_SRC_NMIPIN;
    else if (mask_live[prom_idx])
      src_next = ipr_src_t'(prom_idx + 5'd7);
    else
    begin
      for (int k = NM - 1; k >= 0; k--)
        if (mask_live[k])
          src_next = ipr_src_t'(5'(k) + 5'd7);
    end
  end

  assign vec_next = vec_of(src_next, special_mode_bit_reg);

  // Result is registered so the CPU sees a clean value each cycle
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      pend_reg <= 1'b0;
      src_reg  <= IPR_SRC_NONE;
      vec_reg  <= 16'h0000;
    end
    else
    begin
      pend_reg <= (src_next != IPR_SRC_NONE);
      src_reg  <= src_next;
      vec_reg  <= vec_next;
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  // Unmapped addresses read zero; option bits other than edge are zero
  always_comb
  begin
    rdata_next = 8'h00;
    if (ADDR == `IPR_PRIO_SEL_OFS)
      rdata_next = {boot_rom_enable_bit_reg, special_mode_bit_reg,
                    mode_a_bit_reg, psel_reg};
    else if (ADDR == `IPR_OPTION_OFS)
      rdata_next[`IPR_EDGE_BIT] = ext_int_edge_select_reg;
  end

  // Data stand for the cycle after the strobe only
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      rdata_reg <= 8'h00;
    else if (RD)
      rdata_reg <= rdata_next;
    else
      rdata_reg <= 8'h00;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign RDATA           = rdata_reg;
  assign INT_PENDING     = pend_reg;
  assign INT_SOURCE      = src_reg;
  assign INT_VECTOR      = vec_reg;
  assign BOOT_ROM_MAPPED = boot_rom_enable_bit_reg;
  assign SPECIAL_MODE    = special_mode_bit_reg;
  assign MODE_A          = mode_a_bit_reg;
  assign EXT_EDGE_SEL    = ext_int_edge_select_reg;

endmodule // ipr_resolver

// ==== bench/ipr_resolver_checker.sv ====
// Port-level assertions for the priority resolver
`timescale 1ns/10ps
module ipr_resolver_checker
(
  input wire logic        CLK,               // Clock
  input wire logic        RST_N,             // Async reset, low
  input wire logic        I_MASK,            // CPU I mask
  input wire logic        X_MASK,            // CPU X mask
  input wire logic        RESET_REQ,         // Reset request
  input wire logic        SWI_REQ,           // Software interrupt
  input wire logic        NMI_PIN_N,         // Nonmaskable pin
  input wire logic        SLOW_PERIODIC_INT, // Slow periodic
  input wire logic        MODE_PIN_A,        // Mode strap A
  input wire logic        MODE_PIN_B,        // Mode strap B
  input wire logic        INT_PENDING,       // Request present
  input wire logic [4:0]  INT_SOURCE,        // Winner id
  input wire logic [15:0] INT_VECTOR,        // Winner vector
  input wire logic        BOOT_ROM_MAPPED,   // Boot ROM bit
  input wire logic        SPECIAL_MODE,      // Special bit
  input wire logic        MODE_A,            // Mode A bit
  input wire logic        EXT_EDGE_SEL       // Edge select bit
);
  // ********************************
  // Cycle count and strap copy
  // ********************************
  logic [6:0] cyc_reg;
  logic       pa_reg;
  logic       pb_reg;

  // Saturating count of edges since reset release
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
      cyc_reg <= 7'h00;
    else if (cyc_reg != 7'h7f)
      cyc_reg <= cyc_reg + 7'h01;

  // Straps as the design should see them at its first edge
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
      {pa_reg, pb_reg} <= 2'h0;
    else if (cyc_reg == 7'h00)
      {pa_reg, pb_reg} <= {MODE_PIN_A, MODE_PIN_B};

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  // Answers come one cycle after the requests that cause them
  AST_RESET_FIRST: assert property (
    RESET_REQ |=> INT_SOURCE == 5'h01) else $error("reset not first");
  AST_SWI_NOMASK: assert property (
    SWI_REQ |=> INT_SOURCE inside {[5'h01:5'h05]})
    else $error("swi lost");
  AST_NMI_SHARED: assert property (
    !X_MASK && (!NMI_PIN_N || SLOW_PERIODIC_INT)
    |=> INT_SOURCE inside {[5'h01:5'h06]}) else $error("nmi lost");
  AST_MASKED: assert property (
    X_MASK && I_MASK |=> INT_SOURCE inside {[5'h00:5'h05]})
    else $error("masked source won");
  AST_VECTOR: assert property (
    INT_SOURCE inside {[5'h04:5'h11]}
    |-> INT_VECTOR == 16'hfffe - {10'h000, INT_SOURCE - 5'h01, 1'b0})
    else $error("wrong vector");
  AST_PENDING: assert property (
    INT_PENDING == (INT_SOURCE != 5'h00)) else $error("pending off");
  AST_MODE_RO: assert property (
    !SPECIAL_MODE && cyc_reg > 7'h01
    |=> $stable({BOOT_ROM_MAPPED, SPECIAL_MODE, MODE_A}))
    else $error("mode bits changed");
  AST_EDGE_LOCK: assert property (
    !SPECIAL_MODE && cyc_reg >= 7'h40 |=> $stable(EXT_EDGE_SEL))
    else $error("edge select changed late");
  AST_STRAP: assert property (
    cyc_reg == 7'h01 |-> BOOT_ROM_MAPPED == (!pa_reg && !pb_reg)
    && SPECIAL_MODE == !pb_reg && MODE_A == pa_reg)
    else $error("straps not captured");

  // Main scenarios reached
  COV_PWM: cover property (INT_SOURCE == 5'h12);
  COV_SPECIAL_RESET: cover property (SPECIAL_MODE && INT_SOURCE == 5'h01);
  COV_MASKABLE: cover property (!I_MASK && INT_SOURCE > 5'h06);
endmodule // ipr_resolver_checker

bind ipr_resolver ipr_resolver_checker u_ipr_resolver_checker (.*);

// ==== bench/ipr_cpu_model.sv ====
// CPU core partner holding the condition code masks
`timescale 1ns/10ps
module ipr_cpu_model
(
  input  wire logic clk,     // System clock
  input  wire logic rst_n,   // Async reset, low
  input  wire logic i_cmd,   // Software I mask setting
  input  wire logic x_clr,   // Software clears X mask
  input  wire logic pending, // Resolver has a request
  output logic      i_mask,  // I mask to resolver
  output logic      x_mask,  // X mask to resolver
  output logic      ack      // Request taken
);
  // Masks set out of reset; X may be cleared but never set again
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      i_mask <= 1'b1;
      x_mask <= 1'b1;
    end
    else
    begin
      i_mask <= i_cmd;
      x_mask <= x_mask & ~x_clr;
    end
  end

  // One take per request, then a gap so a held level is seen again
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      ack <= 1'b0;
    else
      ack <= pending & ~ack;
endmodule // ipr_cpu_model

// ==== bench/ipr_resolver_tb.sv ====
// Self-checking bench for the priority resolver
`timescale 1ns/10ps
module ipr_resolver_tb;
  // ********************************
  // Signals, tables and instances
  // ********************************
  logic        CLK = 1'b0, RST_N = 1'b0, WR = 1'b0, RD = 1'b0;
  logic [7:0]  ADDR = 8'h00, WDATA = 8'h00, RDATA;
  logic        RESET_REQ = 1'b0, CLKMON_FAIL = 1'b0, SWI_REQ = 1'b0;
  logic        WATCHDOG_TIMEOUT = 1'b0, ILLEGAL_OPCODE = 1'b0;
  logic        NMI_PIN_N = 1'b1, EXT_INT_PIN_N = 1'b1;
  logic        SLOW_PERIODIC_INT = 1'b0;
  logic        MODE_PIN_A = 1'b0, MODE_PIN_B = 1'b1;
  logic [16:0] PERIPH_REQ = 17'h00000, PERIPH_EN = 17'h00000;
  logic        I_MASK, X_MASK, INT_ACK, INT_PENDING;
  logic [4:0]  INT_SOURCE;
  logic [15:0] INT_VECTOR;
  logic        BOOT_ROM_MAPPED, SPECIAL_MODE, MODE_A, EXT_EDGE_SEL;
  logic        i_cmd = 1'b1, x_clr = 1'b0, spec_e = 1'b0, ma;
  logic [4:0]  psel;
  int          error_cnt = 0, n_checks = 0, cyc = 0;

  // Promoted source for each select code; reserved codes give the pin
  localparam logic [4:0] PTAB [32] = '{5'h07, 5'h07, 5'h07, 5'h07,
    5'h07, 5'h07, 5'h07, 5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d,
    5'h0e, 5'h0f, 5'h10, 5'h11, 5'h13, 5'h14, 5'h17, 5'h18, 5'h07,
    5'h07, 5'h12, 5'h15, 5'h16, 5'h07, 5'h07, 5'h07, 5'h07, 5'h07, 5'h07};
  // Normal-mode vector of each source id
  localparam logic [15:0] VTAB [25] = '{16'h0000, 16'hfffe, 16'hfffc,
    16'hfffa, 16'hfff8, 16'hfff6, 16'hfff4, 16'hfff2, 16'hfff0, 16'hffee,
    16'hffec, 16'hffea, 16'hffe8, 16'hffe6, 16'hffe4, 16'hffe2, 16'hffe0,
    16'hffde, 16'hffd0, 16'hffdc, 16'hffda, 16'hffce, 16'hffcc, 16'hffd8,
    16'hffd6};

  ipr_resolver u_ipr_resolver (.*);
  ipr_cpu_model u_ipr_cpu_model (.clk(CLK), .rst_n(RST_N), .i_cmd(i_cmd),
    .x_clr(x_clr), .pending(INT_PENDING), .i_mask(I_MASK),
    .x_mask(X_MASK), .ack(INT_ACK));

  always #4 CLK = ~CLK;

  // ********************************
  // Expectations and checks
  // ********************************
  // Winner: lowest id among live requests, promoted one ahead of maskables
  function automatic logic [4:0] exp_src();
    logic [24:1] r;
    logic [4:0]  e;
    r = {PERIPH_REQ & PERIPH_EN & {17{!I_MASK}}, !I_MASK && !EXT_INT_PIN_N,
         !X_MASK && (!NMI_PIN_N || SLOW_PERIODIC_INT), SWI_REQ,
         ILLEGAL_OPCODE, WATCHDOG_TIMEOUT, CLKMON_FAIL, RESET_REQ};
    e = 5'h00;
    for (int k = 24; k > 0; k--)
      if (r[k])
        e = 5'(k);
    if (r[6:1] == 6'h00 && r[PTAB[psel]])
      e = PTAB[psel];
    return e;
  endfunction

  // Reset-class vectors move to the special page in special mode
  function automatic logic [15:0] vec(input logic [4:0] s);
    vec = VTAB[s];
    if (spec_e && s != 5'h00 && s < 5'h04)
      vec[14] = 1'b0;
  endfunction

  task automatic chk(input string n, input logic [15:0] s, e);
    n_checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic stop_test();
    if (error_cnt == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ********************************
  // Bus and arbitration drivers
  // ********************************
  task automatic wr(input logic [7:0] a, d);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
    @(posedge CLK);
  endtask

  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, e);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    chk("rdata", RDATA, e);
    @(posedge CLK);
  endtask

  // One arbitration cycle with an optional select write beside it
  task automatic step(input logic w, input logic [7:0] d);
    logic [4:0] e;
    WR <= w;
    ADDR <= 8'h3c;
    WDATA <= d;
    #1;
    e = exp_src();
    if (w && I_MASK)
      psel = d[4:0];
    @(posedge CLK);
    WR <= 1'b0;
    #1;
    chk("source", INT_SOURCE, e);
    chk("vector", INT_VECTOR, vec(e));
    chk("pending", INT_PENDING, e != 5'h00);
    @(posedge CLK);
  endtask

  task automatic do_reset(input logic b, a);
    RST_N <= 1'b0;
    MODE_PIN_B <= b;
    MODE_PIN_A <= a;
    i_cmd <= 1'b1;
    repeat (12) @(posedge CLK);
    RST_N <= 1'b1;
    psel = 5'h06;
    repeat (2) @(posedge CLK);
  endtask

  // Hang guard
  always @(posedge CLK)
  begin
    cyc++;
    if (cyc > 5000)
    begin
      error_cnt++;
      stop_test();
    end
  end

  // ********************************
  // Main sequence
  // ********************************
  initial
  begin
    void'($urandom(96423));
    ma = 1'($urandom);
    do_reset(1'b1, ma);
    rd(8'h3c, {2'b00, ma, 5'h06});
    rd(8'h39, 8'h00);
    wr(8'h39, 8'h00);
    wr(8'h39, 8'h20);
    rd(8'h39, 8'h00);
    rd(8'h3a, 8'h00);
    // Every select code while all maskable sources ask at once
    EXT_INT_PIN_N <= 1'b0;
    PERIPH_REQ <= 17'h1ffff;
    PERIPH_EN <= 17'h1ffff;
    for (int c = 0; c < 32; c++)
    begin
      i_cmd <= 1'b1;
      step(1'b0, 8'h00);
      step(1'b1, 8'(c));
      i_cmd <= 1'b0;
      step(1'b0, 8'h00);
      step(1'b0, 8'h00);
    end
    // Random mix; writes with the I mask clear must be refused
    x_clr <= 1'b1;
    repeat (300)
    begin
      RESET_REQ <= ($urandom % 16) == 0;
      CLKMON_FAIL <= ($urandom % 16) == 0;
      WATCHDOG_TIMEOUT <= ($urandom % 16) == 0;
      ILLEGAL_OPCODE <= ($urandom % 16) == 0;
      SWI_REQ <= ($urandom % 8) == 0;
      NMI_PIN_N <= ($urandom % 6) != 0;
      SLOW_PERIODIC_INT <= ($urandom % 8) == 0;
      EXT_INT_PIN_N <= 1'($urandom);
      PERIPH_REQ <= 17'($urandom);
      PERIPH_EN <= 17'($urandom);
      i_cmd <= 1'($urandom);
      step(($urandom % 3) == 0, 8'($urandom));
    end
    // Late edge select write in normal mode must be refused
    EXT_INT_PIN_N <= 1'b1;
    wr(8'h39, 8'h20);
    rd(8'h39, 8'h00);
    chk("edge sel", EXT_EDGE_SEL, 1'b0);
    rd(8'h3c, {2'b00, ma, psel});
    // Special test mode: mode bits writable until the special bit drops
    do_reset(1'b0, 1'b1);
    spec_e = 1'b1;
    rd(8'h3c, 8'h66);
    chk("mode", {SPECIAL_MODE, MODE_A}, 2'b11);
    RESET_REQ <= 1'b1;
    step(1'b0, 8'h00);
    RESET_REQ <= 1'b0;
    // Edge mode: one falling edge is one request, the take clears it
    {CLKMON_FAIL, WATCHDOG_TIMEOUT, ILLEGAL_OPCODE, SWI_REQ} <= 4'h0;
    {NMI_PIN_N, SLOW_PERIODIC_INT, PERIPH_EN} <= 19'h40000;
    wr(8'h39, 8'h20);
    rd(8'h39, 8'h20);
    chk("edge sel", EXT_EDGE_SEL, 1'b1);
    i_cmd <= 1'b0;
    repeat (2) @(posedge CLK);
    EXT_INT_PIN_N <= 1'b0;
    repeat (2) @(posedge CLK);
    #1;
    chk("edge req", INT_SOURCE, 5'h07);
    repeat (3) @(posedge CLK);
    #1;
    chk("edge take", INT_SOURCE, 5'h00);
    @(posedge CLK);
    i_cmd <= 1'b1;
    repeat (2) @(posedge CLK);
    wr(8'h3c, 8'ha7);
    rd(8'h3c, 8'ha7);
    chk("boot", BOOT_ROM_MAPPED, 1'b1);
    wr(8'h3c, 8'h06);
    rd(8'h3c, 8'ha6);
    stop_test();
  end
endmodule // ipr_resolver_tb
